// File: rtl/softstop_map.vh
// command codes, field layouts, reset values and timing for soft-stop block
`ifndef SOFTSTOP_MAP_VH
`define SOFTSTOP_MAP_VH

`define CMD_FALL_TIME 8'h65
`define CMD_FAULT_SUMMARY 8'h78

`define FALL_FIXED_HI 12'hf80
`define FALL_MANT_RST 4'h0
`define FALL_MANT_MSB 3
`define FALL_FIXED_LSB 4

`define REST_MANT_0P5 4'h0
`define REST_MANT_1 4'h2
`define REST_MANT_2 4'h4
`define REST_MANT_4 4'h8

`define MANT_TH_1MS 4'h2
`define MANT_TH_2MS 4'h4
`define MANT_TH_4MS 4'h8

`define SUM_OFF 6
`define SUM_OVF 5
`define SUM_OCF 4
`define SUM_TEMP 2
`define SUM_CML 1
`define SUM_OTH 0
`define VSTAT_OVF 7
`define ISTAT_OCF 7
`define ISTAT_OVERCURRENT_UNDERVOLTAGE_FLAG 6

`define CLK_PERIOD_NS 4
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)

`define DAC_LSB_MV 5
`define CUTOFF_MV 200
`define CUTOFF_CODE (`CUTOFF_MV / `DAC_LSB_MV)
`define BOOT_CODE_STEP 32
`define BOOT_CODE_FILL 5'h1f
`define FRAC_BITS 8
`define STEP_BASE 16

`endif

// File: rtl/softstop_ramp.v
// reference dac down-ramp generator with microsecond tick
`include "softstop_map.vh"

module softstop_ramp #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter ACC_W = 18
) (
   input wire clk,
   input wire resetn,
   input wire load,
   input wire [ACC_W-1:0] load_value,
   input wire run,
   input wire [1:0] shift,
   input wire [4:0] level,
   output reg [ACC_W-`FRAC_BITS-1:0] ref_code_ff,
   output reg done_ff
);

   reg [ACC_W-1:0] acc_ff;
   reg [15:0] tick_ff;
   wire tick;
   wire [ACC_W-1:0] base_step;
   wire [ACC_W-1:0] step;
   wire [ACC_W-1:0] acc_dec;

   assign tick = (tick_ff == TICK_CYCLES - 1);
   // slew per boot level, (level + 1) times STEP_BASE, shifted per setting
   assign base_step = (level + 1'b1) * `STEP_BASE;
   assign step = base_step >> shift;
   assign acc_dec = acc_ff - step;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_ff <= 16'h0000;
      end else if (!run || tick) begin
         tick_ff <= 16'h0000;
      end else begin
         tick_ff <= tick_ff + 16'h0001;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_ff <= {ACC_W{1'b0}};
         ref_code_ff <= {(ACC_W-`FRAC_BITS){1'b0}};
         done_ff <= 1'b0;
      end else begin
         if (load) begin
            acc_ff <= load_value;
            done_ff <= 1'b0;
            ref_code_ff <= load_value[ACC_W-1:`FRAC_BITS];
         end else if (run && tick) begin
            // reference walks down to exactly zero
            if (acc_ff <= step) begin
               acc_ff <= {ACC_W{1'b0}};
               ref_code_ff <= {(ACC_W-`FRAC_BITS){1'b0}};
               done_ff <= 1'b1;
            end else begin
               acc_ff <= acc_dec;
               ref_code_ff <= acc_dec[ACC_W-1:`FRAC_BITS];
            end
         end
      end
   end

endmodule // softstop_ramp

// File: rtl/softstop_fault_summary.v
// soft-stop fall-time command, reference ramp control and fault summary byte
`include "softstop_map.vh"

module softstop_fault_summary #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter DAC_W = 10
) (
   input wire clk,
   input wire resetn,
   input wire cmd_valid,
   input wire cmd_write,
   input wire cmd_word,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   input wire nvm_restore,
   input wire [1:0] nvm_fall_sel,
   input wire power_up,
   input wire softstop_start,
   input wire [4:0] boot_voltage_level,
   input wire [DAC_W-1:0] vout_code,
   input wire secondary_mode,
   input wire [7:0] output_voltage_status,
   input wire [7:0] output_current_status,
   input wire temperature_summary_flag,
   input wire cml_fault,
   input wire other_fault_flag,
   output reg rsp_valid_ff,
   output reg rsp_nack_ff,
   output reg [15:0] rsp_data_ff,
   output reg invalid_data_set_ff,
   output reg [3:0] softstop_fall_time_ff,
   output reg [1:0] fall_setting_ff,
   output reg switch_en_ff,
   output reg [DAC_W-1:0] ref_target_ff,
   output reg softstop_done_ff,
   output reg [7:0] fault_summary_ff
);

   localparam ACC_W = DAC_W + `FRAC_BITS;
   localparam ST_OFF = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_RAMP = 2'b10;
   localparam ST_DONE = 2'b11;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg nxt_switch_en;
   reg ramp_load;
   reg ramp_run;
   reg [ACC_W-1:0] ramp_value;
   reg nxt_rsp_valid;
   reg nxt_rsp_nack;
   reg [15:0] nxt_rsp_data;
   reg nxt_invalid;
   reg [3:0] nxt_mant;
   reg [7:0] nxt_summary;
   wire [DAC_W-1:0] ramp_code;
   wire ramp_done;
   wire fall_wr;
   wire fall_bad;
   wire [ACC_W-1:0] boot_acc;

   // supported setting rounded down from the mantissa: 0=0.5ms 1=1ms 2=2ms 3=4ms
   function [1:0] fall_sel;
      input [3:0] mant;
      begin
         if (mant < `MANT_TH_1MS) begin
            fall_sel = 2'd0;
         end else if (mant < `MANT_TH_2MS) begin
            fall_sel = 2'd1;
         end else if (mant < `MANT_TH_4MS) begin
            fall_sel = 2'd2;
         end else begin
            fall_sel = 2'd3;
         end
      end
   endfunction

   // fixed mantissa stored back for each supported setting
   function [3:0] restore_mant;
      input [1:0] sel;
      begin
         case (sel)
            2'd0: restore_mant = `REST_MANT_0P5;
            2'd1: restore_mant = `REST_MANT_1;
            2'd2: restore_mant = `REST_MANT_2;
            default: restore_mant = `REST_MANT_4;
         endcase
      end
   endfunction

   function [15:0] fall_word;
      input [3:0] mant;
      begin
         fall_word = {`FALL_FIXED_HI, mant};
      end
   endfunction

   assign fall_wr = cmd_valid && cmd_write &&
      (cmd_code == `CMD_FALL_TIME);
   // any change to the fixed upper field is refused
   assign fall_bad = !cmd_word ||
      (cmd_wdata[15:`FALL_FIXED_LSB] != `FALL_FIXED_HI);
   // top of each boot level band, so level 31 still fits the dac code
   assign boot_acc = {boot_voltage_level, `BOOT_CODE_FILL,
      {`FRAC_BITS{1'b0}}};

   // command decode and response
   always @* begin
      nxt_rsp_valid = cmd_valid;
      nxt_rsp_nack = 1'b0;
      nxt_rsp_data = 16'h0000;
      nxt_invalid = 1'b0;
      nxt_mant = softstop_fall_time_ff;
      if (nvm_restore) begin
         nxt_mant = restore_mant(nvm_fall_sel);
      end
      if (cmd_valid) begin
         case (cmd_code)
            `CMD_FALL_TIME: begin
               if (!cmd_write) begin
                  nxt_rsp_data = fall_word(softstop_fall_time_ff);
               end else if (fall_bad) begin
                  nxt_rsp_nack = 1'b1;
                  nxt_invalid = 1'b1;
               end else begin
                  // value kept as written
                  nxt_mant = cmd_wdata[`FALL_MANT_MSB:0];
               end
            end
            `CMD_FAULT_SUMMARY: begin
               if (cmd_write || cmd_word) begin
                  nxt_rsp_nack = 1'b1;
                  nxt_invalid = 1'b1;
               end else begin
                  nxt_rsp_data = {8'h00, fault_summary_ff};
               end
            end
            default: begin
               nxt_rsp_nack = 1'b1;
            end
         endcase
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid_ff <= 1'b0;
         rsp_nack_ff <= 1'b0;
         rsp_data_ff <= 16'h0000;
         invalid_data_set_ff <= 1'b0;
         softstop_fall_time_ff <= `FALL_MANT_RST;
         fall_setting_ff <= 2'd0;
      end else begin
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_nack_ff <= nxt_rsp_nack;
         rsp_data_ff <= nxt_rsp_data;
         invalid_data_set_ff <= nxt_invalid;
         softstop_fall_time_ff <= nxt_mant;
         fall_setting_ff <= fall_sel(nxt_mant);
      end
   end

   // summary byte built from live detailed sources
   always @* begin
      nxt_summary = 8'h00;
      nxt_summary[`SUM_OFF] = !switch_en_ff;
      nxt_summary[`SUM_OVF] = output_voltage_status[`VSTAT_OVF];
      nxt_summary[`SUM_OCF] = output_current_status[`ISTAT_OCF] |
         output_current_status[`ISTAT_OVERCURRENT_UNDERVOLTAGE_FLAG];
      nxt_summary[`SUM_TEMP] = temperature_summary_flag;
      nxt_summary[`SUM_CML] = cml_fault;
      nxt_summary[`SUM_OTH] = other_fault_flag;
      if (secondary_mode) begin
         nxt_summary = 8'h00;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fault_summary_ff <= 8'h40;
      end else begin
         fault_summary_ff <= nxt_summary;
      end
   end

   // power-stage sequencing
   always @* begin
      nxt_state = state_ff;
      nxt_switch_en = switch_en_ff;
      ramp_load = 1'b0;
      ramp_run = 1'b0;
      ramp_value = boot_acc;
      case (state_ff)
         ST_OFF: begin
            nxt_switch_en = 1'b0;
            if (power_up) begin
               ramp_load = 1'b1;
               nxt_switch_en = 1'b1;
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (softstop_start) begin
               // start from the present reference
               ramp_load = 1'b1;
               ramp_value = {ref_target_ff, {`FRAC_BITS{1'b0}}};
               nxt_state = ST_RAMP;
            end
         end
         ST_RAMP: begin
            ramp_run = 1'b1;
            if (vout_code <= `CUTOFF_CODE) begin
               nxt_switch_en = 1'b0;
            end
            if (ramp_done) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_switch_en = 1'b0;
            nxt_state = ST_OFF;
         end
         default: begin
            nxt_switch_en = 1'b0;
            nxt_state = ST_OFF;
         end
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_OFF;
         switch_en_ff <= 1'b0;
         ref_target_ff <= {DAC_W{1'b0}};
         softstop_done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         switch_en_ff <= nxt_switch_en;
         ref_target_ff <= ramp_code;
         softstop_done_ff <= (state_ff == ST_DONE);
      end
   end

   softstop_ramp #(
      .TICK_CYCLES(TICK_CYCLES),
      .ACC_W(ACC_W)
   ) u_ramp (
      .clk(clk),
      .resetn(resetn),
      .load(ramp_load),
      .load_value(ramp_value),
      .run(ramp_run),
      .shift(fall_setting_ff),
      .level(boot_voltage_level),
      .ref_code_ff(ramp_code),
      .done_ff(ramp_done)
   );

endmodule // softstop_fault_summary

// File: bench/plant_model.sv
// output stage model: vout tracks reference while switching, decays otherwise
module plant_model (
   input wire clk,
   input wire resetn,
   input wire switch_en,
   input wire [9:0] ref_target,
   output reg [9:0] vout_code
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) vout_code <= 10'h000;
      else if (switch_en) vout_code <= ref_target;
      else if (vout_code != 10'h000) vout_code <= vout_code - 10'h001;
   end
endmodule // plant_model

// File: bench/softstop_fault_summary_properties.sv
// assertions for fall-time command, ramp and summary byte
module softstop_checks (
   input wire clk,
   input wire resetn,
   input wire cmd_valid,
   input wire cmd_write,
   input wire cmd_word,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   input wire nvm_restore,
   input wire secondary_mode,
   input wire [7:0] output_voltage_status,
   input wire [7:0] output_current_status,
   input wire cml_fault,
   input wire rsp_valid_ff,
   input wire rsp_nack_ff,
   input wire invalid_data_set_ff,
   input wire [3:0] softstop_fall_time_ff,
   input wire [1:0] fall_setting_ff,
   input wire switch_en_ff,
   input wire [9:0] ref_target_ff,
   input wire softstop_done_ff,
   input wire [7:0] fault_summary_ff
);
   wire [3:0] wmant = cmd_wdata[3:0];
   wire w65 = cmd_valid && cmd_write && cmd_code == 8'h65;
   function automatic [1:0] fmap(input [3:0] m);
      fmap = m < 4'h2 ? 2'h0 : m < 4'h4 ? 2'h1 : m < 4'h8 ? 2'h2 : 2'h3;
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rsp_latency: assert property ($past(resetn) |->
      rsp_valid_ff == $past(cmd_valid)) else $error("response latency");
   a_mant_write: assert property (w65 && cmd_word && cmd_wdata[15:4] == 12'hf80
      |=> !rsp_nack_ff && softstop_fall_time_ff == $past(wmant))
      else $error("mantissa write");
   a_fixed_bits: assert property (w65 && !nvm_restore && cmd_wdata[15:4] != 12'hf80
      |=> rsp_nack_ff && invalid_data_set_ff && $stable(softstop_fall_time_ff))
      else $error("read-only field write");
   a_setting_map: assert property ($past(resetn) |->
      fall_setting_ff == fmap(softstop_fall_time_ff)) else $error("setting");
   a_summary_ro: assert property (cmd_valid && cmd_code == 8'h78 &&
      (cmd_write || cmd_word) |=> rsp_nack_ff && invalid_data_set_ff)
      else $error("summary write");
   a_second_zero: assert property ($past(resetn) && $past(secondary_mode)
      |-> fault_summary_ff == 8'h00) else $error("secondary");
   a_unused_zero: assert property (!fault_summary_ff[7] && !fault_summary_ff[3])
      else $error("unused bits");
   a_off_live: assert property ($past(resetn) && !$past(secondary_mode) |->
      fault_summary_ff[6] == !$past(switch_en_ff)) else $error("off bit");
   a_ovf_mirror: assert property ($past(resetn) && !$past(secondary_mode) |->
      fault_summary_ff[5] == $past(output_voltage_status[7])) else $error("ovf");
   a_ocf_either: assert property ($past(resetn) && !$past(secondary_mode) |->
      fault_summary_ff[4] == |$past(output_current_status[7:6])) else $error("ocf");
   a_cml_follow: assert property ($past(resetn) && !$past(secondary_mode) |->
      fault_summary_ff[1] == $past(cml_fault)) else $error("cml");
   a_done_zero: assert property (softstop_done_ff |-> ref_target_ff == 10'h000)
      else $error("ramp end");
   c_done: cover property (softstop_done_ff);
   c_refuse: cover property (invalid_data_set_ff);
   c_cutoff: cover property ($fell(switch_en_ff));
endmodule // softstop_checks
bind softstop_fault_summary softstop_checks softstop_checks_i (.*);

// File: bench/softstop_fault_summary_bench.sv
// self-checking bench for the fall-time command and summary byte
module softstop_fault_summary_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam TK = 4;
   reg clk = 0, resetn = 0, cmd_valid = 0, cmd_write = 0, cmd_word = 0;
   reg nvm_restore = 0, power_up = 0, softstop_start = 0, secondary_mode = 0;
   reg temperature_summary_flag = 0, cml_fault = 0, other_fault_flag = 0;
   reg [7:0] cmd_code = 0, output_voltage_status = 0, output_current_status = 0;
   reg [15:0] cmd_wdata = 0;
   reg [1:0] nvm_fall_sel = 0;
   reg [4:0] boot_voltage_level = 0;
   reg [6:0] src;
   wire [9:0] vout_code, ref_target_ff;
   wire rsp_valid_ff, rsp_nack_ff, invalid_data_set_ff, switch_en_ff;
   wire softstop_done_ff;
   wire [15:0] rsp_data_ff;
   wire [3:0] softstop_fall_time_ff;
   wire [1:0] fall_setting_ff;
   wire [7:0] fault_summary_ff;
   int n_fail = 0, compares = 0, i, n, e;
   reg sw;
   softstop_fault_summary #(.TICK_CYCLES(TK)) softstop_fault_summary_i (.*);
   plant_model plant_model_i (.clk(clk), .resetn(resetn),
      .switch_en(switch_en_ff), .ref_target(ref_target_ff),
      .vout_code(vout_code));
   initial forever #2 clk = ~clk;
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cmd(input logic w, wd, input logic [7:0] c, input logic [15:0] d,
      input logic nk, iv, input logic [15:0] rd);
      @(negedge clk);
      {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata} = {1'b1, w, wd, c, d};
      @(negedge clk);
      cmd_valid = 0;
      chk({rsp_valid_ff, rsp_nack_ff, invalid_data_set_ff}, {1'b1, nk, iv});
      chk(rsp_data_ff, rd);
   endtask
   task test_done;
      $display("compares %0d failures %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(60000 * TK);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (16) @(negedge clk);
      resetn = 1;
      cmd(0, 1, 8'h65, 0, 0, 0, 16'hf800);
      cmd(0, 0, 8'h78, 0, 0, 0, 16'h0040);
      $display("reset test ended");
      for (i = 0; i < 16; i++) begin
         cmd(1, 1, 8'h65, {12'hf80, i[3:0]}, 0, 0, 0);
         cmd(0, 1, 8'h65, 0, 0, 0, {12'hf80, i[3:0]});
         chk(fall_setting_ff, i < 2 ? 0 : i < 4 ? 1 : i < 8 ? 2 : 3);
      end
      cmd(1, 1, 8'h65, 16'h0807, 1, 1, 0);
      cmd(1, 0, 8'h65, 16'hf803, 1, 1, 0);
      cmd(0, 1, 8'h65, 0, 0, 0, 16'hf80f);
      cmd(1, 0, 8'h78, 16'h0001, 1, 1, 0);
      cmd(0, 1, 8'h78, 0, 1, 1, 0);
      cmd(0, 0, 8'h10, 0, 1, 0, 0);
      for (i = 0; i < 4; i++) begin
         @(negedge clk);
         {nvm_restore, nvm_fall_sel} = {1'b1, i[1:0]};
         @(negedge clk);
         nvm_restore = 0;
         chk(softstop_fall_time_ff, i == 0 ? 0 : 1 << i);
      end
      $display("command test ended");
      for (i = 0; i < 8; i++) begin
         src = i < 7 ? 7'h01 << i : 7'h7f;
         output_voltage_status = {src[0], 7'h7f};
         output_current_status = {src[1], src[2], 6'h3f};
         {temperature_summary_flag, cml_fault, other_fault_flag} = src[5:3];
         cmd(0, 0, 8'h78, 0, 0, 0, {9'h001, src[0], |src[2:1], 1'b0, src[5:3]});
      end
      secondary_mode = 1;
      repeat (2) @(negedge clk);
      chk(fault_summary_ff, 0);
      secondary_mode = 0;
      $display("summary test ended");
      for (i = 0; i < 2; i++) begin
         boot_voltage_level = i ? 5'h03 : 5'h1f;
         cmd(1, 1, 8'h65, i ? 16'hf802 : 16'hf800, 0, 0, 0);
         @(negedge clk);
         power_up = 1;
         @(negedge clk);
         power_up = 0;
         @(negedge clk);
         chk(ref_target_ff, (boot_voltage_level + 1) * 32 - 1);
         repeat (2) @(negedge clk);
         chk({switch_en_ff, fault_summary_ff[6]}, 2'b10);
         softstop_start = 1;
         @(negedge clk);
         softstop_start = 0;
         n = 0;
         sw = 1;
         e = (512 << i) * TK;
         while (!softstop_done_ff && n < 30000) begin
            @(negedge clk);
            n++;
            if (sw && !switch_en_ff) begin
               sw = 0;
               chk(vout_code <= 40 && ref_target_ff != 0, 1);
            end
         end
         chk(n >= e - 40 && n <= e + 40, 1);
         repeat (3) @(negedge clk);
         chk(fault_summary_ff[6], 1);
      end
      $display("soft-stop test ended");
      test_done;
   end
endmodule // softstop_fault_summary_bench
